// [iso_desc_engine.sv]
// High-speed isochronous descriptor engine with AXI4-Lite register access
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "iso_desc_regs.svh"

// Behaviour
// - Write 12-bit count for active, matching micro-frame
// - Status: error, babble on IN, underrun on OUT
// - Transact only enabled micro-frames; clear after processing
// - Stall sets halt; halt clears valid
// - Descriptor babble flag unused, written zero
// - Accumulate 15-bit moved total, saturating
// - Split select picks split or high-speed
// - Token 00 sends OUT, 01 sends IN
// - Address: 7-bit function, split 4-bit endpoint
// - Burst count passed as packets per execution
// - Packet size limit up to 1024 bytes
// - Valid cleared when done or fatal error

module iso_desc_engine (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic uframe_start,
    input wire logic [2:0] uframe_index,
    input wire logic [4:0] bus_frame_number,
    output logic xact_req,
    output var iso_desc_pkg::xact_req_t xact_cmd,
    input wire logic xact_ack,
    input wire logic xact_done,
    input wire iso_desc_pkg::xact_res_t xact_result,
    output logic irq
);

    // Register access strobes from the bus front end
    logic wr_en;
    logic wr_ok;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic rd_en;
    logic rd_ok;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;

    // Descriptor image and engine state
    logic [255:0] desc_q;
    logic [255:0] desc_d;
    iso_desc_pkg::state_t state_q;
    iso_desc_pkg::state_t state_d;
    logic [2:0] cur_uf_q;
    logic enable_q;
    logic [2:0] irq_mask_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_stat_d;
    logic [2:0] irq_ev;
    logic irq_q;
    logic xact_req_q;
    iso_desc_pkg::xact_req_t cmd_q;

    // Decoded descriptor fields
    logic desc_valid;
    logic desc_active;
    logic desc_halt;
    logic [1:0] desc_token;
    logic [1:0] desc_kind;
    logic [4:0] frame_sel;
    logic [7:0] uframe_enable_mask;
    logic [14:0] moved_byte_total;
    logic [7:0] mask_left;
    logic [15:0] moved_sum;
    logic result_take;
    logic last_uf;
    logic run_ok;
    logic frame_hit;

    // Word-aligned addresses up to the engine register are mapped
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a[1:0] == 2'h0) && (a <= `REG_ENGINE);
    endfunction

    // Descriptor word index of a byte address
    function automatic logic [2:0] reg_word(input logic [7:0] a);
        reg_word = a[4:2];
    endfunction

    iso_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // Field views of the descriptor
    assign desc_valid = desc_q[`F_VALID];
    assign desc_active = desc_q[`F_ACTIVE];
    assign desc_halt = desc_q[`F_HALT];
    assign desc_token = desc_q[`F_TOKEN +: 2];
    assign desc_kind = desc_q[`F_KIND +: 2];
    assign frame_sel = desc_q[`F_FRAME_SEL +: 5];
    assign uframe_enable_mask = desc_q[`F_MASK +: 8];
    assign moved_byte_total = desc_q[`F_MOVED +: 15];

    // Result bookkeeping
    assign result_take = (state_q == iso_desc_pkg::ST_WAIT) && xact_done;
    assign mask_left = uframe_enable_mask & ~(8'h01 << cur_uf_q);
    assign last_uf = (mask_left == 8'h00);
    assign moved_sum = {1'b0, moved_byte_total} + {4'h0, xact_result.rx_count};
    assign wr_ok = reg_hit(wr_addr);

    // Runs only on an enabled, valid, unhalted isochronous descriptor
    assign run_ok = enable_q && desc_valid && desc_active && !desc_halt && (desc_kind == `KIND_ISO);
    // Low three select bits are don't-care, so only the frame part is compared
    assign frame_hit = (frame_sel == bus_frame_number);

    // Register read mux
    always_comb begin
        rd_ok = reg_hit(rd_addr);
        rd_data = 32'h0;
        if (rd_addr < `REG_CTRL) begin
            rd_data = desc_q[{reg_word(rd_addr), 5'h00} +: 32];
        end else begin
            case (rd_addr)
                `REG_CTRL: rd_data = {31'h0, enable_q};
                `REG_IRQ_STAT: rd_data = {29'h0, irq_stat_q};
                `REG_IRQ_MASK: rd_data = {29'h0, irq_mask_q};
                `REG_ENGINE: rd_data = {25'h0, cur_uf_q, state_q};
                default: rd_data = 32'h0;
            endcase
        end
    end

    // Descriptor next value: software bytes first, then hardware write-back
    always_comb begin
        desc_d = desc_q;
        if (wr_en && wr_ok && (wr_addr < `REG_CTRL)) begin
            for (int b = 0; b < 4; b++) begin
                if (wr_strb[b]) begin
                    desc_d[{reg_word(wr_addr), 2'(b), 3'h0} +: 8] = wr_data[8*b +: 8];
                end
            end
        end
        if (result_take) begin
            desc_d[`F_COUNT + 12*cur_uf_q +: 12] = xact_result.rx_count;
            desc_d[`F_RESULT + 3*cur_uf_q] = xact_result.xact_error;
            desc_d[`F_RESULT + 3*cur_uf_q + 1] = xact_result.babble && (desc_token == `TOKEN_IN);
            desc_d[`F_RESULT + 3*cur_uf_q + 2] = xact_result.underrun && (desc_token == `TOKEN_OUT);
            // Saturate rather than wrap past the 15-bit limit
            desc_d[`F_MOVED +: 15] = moved_sum[15] ? `MOVED_MAX : moved_sum[14:0];
            desc_d[`F_MASK + cur_uf_q] = 1'b0;
            desc_d[`F_BABBLE] = 1'b0;
            if (xact_result.stall) begin
                desc_d[`F_HALT] = 1'b1;
            end
            if (last_uf || xact_result.stall) begin
                desc_d[`F_VALID] = 1'b0;
                desc_d[`F_ACTIVE] = 1'b0;
            end
        end
        // A set halt always retires the descriptor, even if software re-validates it
        if (desc_d[`F_HALT]) begin
            desc_d[`F_VALID] = 1'b0;
            desc_d[`F_ACTIVE] = 1'b0;
        end
    end

    // Descriptor storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            desc_q <= 256'h0;
        end else begin
            desc_q <= desc_d;
        end
    end

    // Engine sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            iso_desc_pkg::ST_IDLE: begin
                if (run_ok) begin
                    state_d = iso_desc_pkg::ST_ARMED;
                end
            end
            iso_desc_pkg::ST_ARMED: begin
                if (!run_ok) begin
                    state_d = iso_desc_pkg::ST_IDLE;
                end else if (uframe_start && frame_hit && uframe_enable_mask[uframe_index]) begin
                    state_d = iso_desc_pkg::ST_ISSUE;
                end
            end
            iso_desc_pkg::ST_ISSUE: begin
                if (xact_ack) begin
                    state_d = iso_desc_pkg::ST_WAIT;
                end
            end
            iso_desc_pkg::ST_WAIT: begin
                if (xact_done) begin
                    state_d = iso_desc_pkg::ST_ARMED;
                end
            end
            default: state_d = iso_desc_pkg::ST_IDLE;
        endcase
    end

    // State register and current micro-frame
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= iso_desc_pkg::ST_IDLE;
            cur_uf_q <= 3'h0;
        end else begin
            state_q <= state_d;
            if ((state_q == iso_desc_pkg::ST_ARMED) && (state_d == iso_desc_pkg::ST_ISSUE)) begin
                cur_uf_q <= uframe_index;
            end
        end
    end

    // Transaction request; command captured once so a rewrite mid-flight cannot tear it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xact_req_q <= 1'b0;
            cmd_q <= '0;
        end else begin
            if ((state_q == iso_desc_pkg::ST_ARMED) && (state_d == iso_desc_pkg::ST_ISSUE)) begin
                xact_req_q <= 1'b1;
                cmd_q.token <= desc_token;
                cmd_q.split <= desc_q[`F_SPLIT];
                cmd_q.function_number <= desc_q[`F_FUNC +: 7];
                cmd_q.endpoint_number <= {desc_q[`F_EP_HIGH +: 3], desc_q[`F_EP_LOW]};
                cmd_q.packet_size_limit <= desc_q[`F_PKT_LIMIT +: 11];
                cmd_q.burst_count <= desc_q[`F_BURST +: 2];
                cmd_q.buffer_start <= desc_q[`F_BUF_START +: 16];
            end else if (xact_ack) begin
                xact_req_q <= 1'b0;
            end
        end
    end

    // Control and mask registers written by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_q <= `CTRL_RESET;
            irq_mask_q <= `IRQ_MASK_RESET;
        end else if (wr_en && wr_strb[0]) begin
            if (wr_addr == `REG_CTRL) begin
                enable_q <= wr_data[0];
            end
            if (wr_addr == `REG_IRQ_MASK) begin
                irq_mask_q <= wr_data[2:0];
            end
        end
    end

    // Interrupt events; a new event in the clearing read's cycle survives
    always_comb begin
        irq_ev = 3'h0;
        irq_ev[`IRQ_UFRAME] = result_take;
        irq_ev[`IRQ_DESC_DONE] = result_take && (last_uf || xact_result.stall);
        irq_ev[`IRQ_HALT] = result_take && xact_result.stall;
        irq_stat_d = irq_stat_q;
        if (rd_en && (rd_addr == `REG_IRQ_STAT)) begin
            irq_stat_d = 3'h0;
        end
        irq_stat_d = irq_stat_d | irq_ev;
    end

    // Sticky status and level interrupt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= 3'h0;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_q <= |(irq_stat_d & irq_mask_q);
        end
    end

    assign xact_req = xact_req_q;
    assign xact_cmd = cmd_q;
    assign irq = irq_q;

endmodule // iso_desc_engine

`default_nettype wire

// [iso_desc_regs.svh]
// Register offsets, descriptor field positions and reset values
`ifndef ISO_DESC_REGS_SVH
`define ISO_DESC_REGS_SVH

// Byte offsets on the register bus; descriptor words sit at 0x00..0x1c
`define REG_DESC 8'h00
`define REG_CTRL 8'h20
`define REG_IRQ_STAT 8'h24
`define REG_IRQ_MASK 8'h28
`define REG_ENGINE 8'h2c

// Bit positions inside the 256-bit descriptor image (word n = bits 32n+31..32n)
`define F_VALID 0
`define F_REQ_TOTAL 3
`define F_PKT_LIMIT 18
`define F_BURST 29
`define F_EP_LOW 31
`define F_EP_HIGH 32
`define F_FUNC 35
`define F_TOKEN 42
`define F_KIND 44
`define F_SPLIT 46
`define F_FRAME_SEL 67
`define F_BUF_START 72
`define F_MOVED 96
`define F_BABBLE 125
`define F_HALT 126
`define F_ACTIVE 127
`define F_MASK 128
`define F_RESULT 136
`define F_COUNT 160

// Encodings and limits
`define KIND_ISO 2'h1
`define TOKEN_OUT 2'h0
`define TOKEN_IN 2'h1
`define MOVED_MAX 15'h7fff
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Interrupt bit positions and reset values
`define IRQ_UFRAME 0
`define IRQ_DESC_DONE 1
`define IRQ_HALT 2
`define CTRL_RESET 1'h0
`define IRQ_MASK_RESET 3'h0

`endif

// [iso_desc_pkg.sv]
// Types shared by the descriptor engine and its users
package iso_desc_pkg;

    // Engine states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ARMED = 4'h2,
        ST_ISSUE = 4'h4,
        ST_WAIT = 4'h8
    } state_t;

    // One transaction handed to the bus executor
    typedef struct packed {
        logic [1:0] token;
        logic split;
        logic [6:0] function_number;
        logic [3:0] endpoint_number;
        logic [10:0] packet_size_limit;
        logic [1:0] burst_count;
        logic [15:0] buffer_start;
    } xact_req_t;

    // Outcome reported by the bus executor
    typedef struct packed {
        logic [11:0] rx_count;
        logic xact_error;
        logic babble;
        logic underrun;
        logic stall;
    } xact_res_t;

endpackage

// [iso_axil_slave.sv]
// AXI4-Lite slave front end turning bus channels into access strobes
`timescale 1ns/100ps
`default_nettype none
`include "iso_desc_regs.svh"

module iso_axil_slave (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic rd_en,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);

    logic aw_full_q, w_full_q, ar_full_q;

    // Access happens once the address (and for writes the data) is held and no response is pending
    assign wr_en = aw_full_q && w_full_q && !bvalid;
    assign rd_en = ar_full_q && !rvalid;

    // Write path: address and data latched in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            wr_addr <= 8'h0;
            wr_data <= 32'h0;
            wr_strb <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                wr_addr <= awaddr;
                aw_full_q <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wr_data <= wdata;
                wr_strb <= wstrb;
                w_full_q <= 1'b1;
                wready <= 1'b0;
            end
            if (wr_en) begin
                bvalid <= 1'b1;
                bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
            end
            // Readies reopen only after the response, so one write at a time
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Read path; unmapped addresses answer SLVERR with zero data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            ar_full_q <= 1'b0;
            rvalid <= 1'b0;
            rresp <= `RESP_OKAY;
            rdata <= 32'h0;
            rd_addr <= 8'h0;
        end else begin
            if (arvalid && arready) begin
                rd_addr <= araddr;
                ar_full_q <= 1'b1;
                arready <= 1'b0;
            end
            if (rd_en) begin
                rvalid <= 1'b1;
                rdata <= rd_ok ? rd_data : 32'h0;
                rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
                ar_full_q <= 1'b0;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

endmodule // iso_axil_slave

`default_nettype wire

// [iso_desc_engine_assertions.sv]
// Port-level assertions for the isochronous descriptor engine
`timescale 1ns/100ps
`default_nettype none

module iso_desc_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic uframe_start,
    input wire logic xact_req,
    input wire iso_desc_pkg::xact_req_t xact_cmd,
    input wire logic xact_ack,
    input wire logic xact_done
);
    logic wait_q;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Open from an accepted request until its result arrives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_q <= 1'b0;
        end else if (xact_ack && xact_req) begin
            wait_q <= 1'b1;
        end else if (xact_done) begin
            wait_q <= 1'b0;
        end
    end

    req_hold_a: assert property (xact_req && !xact_ack |=> xact_req && $stable(xact_cmd))
        else $error("Request or command changed before acceptance");
    req_drop_a: assert property (xact_req && xact_ack |=> !xact_req)
        else $error("Request held after acceptance");
    req_cause_a: assert property ($rose(xact_req) |-> $past(uframe_start))
        else $error("Request raised without a micro-frame start");
    one_xact_a: assert property (wait_q |-> !xact_req)
        else $error("New request while a transaction is open");
    // The access strobe fires one edge after the take, so the answer shows two edges after it
    wr_answer_a: assert property (awvalid && awready && wvalid && wready |=> !awready ##1 bvalid)
        else $error("Write not answered two cycles after both channels taken");
    b_done_a: assert property (bvalid && bready |=> !bvalid && awready && wready)
        else $error("Write response not retired");
    rd_answer_a: assert property (arvalid && arready |=> !arready ##1 rvalid)
        else $error("Read not answered two cycles after address taken");
    r_done_a: assert property (rvalid && rready |=> !rvalid && arready)
        else $error("Read response not retired");
endmodule // iso_desc_checker

bind iso_desc_engine iso_desc_checker chk_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
    .uframe_start(uframe_start), .xact_req(xact_req), .xact_cmd(xact_cmd), .xact_ack(xact_ack),
    .xact_done(xact_done));
`default_nettype wire

// [iso_bus_executor.sv]
// Behavioural bus executor answering the engine's transaction requests
`timescale 1ns/100ps
`default_nettype none

module iso_bus_executor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic xact_req,
    input wire logic [3:0] lat,
    input wire iso_desc_pkg::xact_res_t res_in,
    output logic xact_ack,
    output logic xact_done,
    output var iso_desc_pkg::xact_res_t xact_result
);
    logic busy_q;
    logic [3:0] cnt_q;

    // Ack lat+1 cycles after the request, done lat+1 after the ack; result toggles outside done so stale data is never trusted
    always_ff @(posedge aclk) begin
        xact_ack <= 1'b0;
        xact_done <= 1'b0;
        xact_result <= ~xact_result;
        if (!aresetn) begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            xact_result <= 16'h0;
        end else if (busy_q || xact_req) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == lat) begin
                cnt_q <= 4'h0;
                busy_q <= !busy_q;
                xact_ack <= !busy_q;
                xact_done <= busy_q;
                if (busy_q) xact_result <= res_in; // Result valid only with done
            end
        end
    end
endmodule // iso_bus_executor
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the isochronous descriptor engine
`timescale 1ns/100ps
`default_nettype none
`include "iso_desc_regs.svh"
`define chk(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("Error %s expected %h seen %h", n, e, g); end end

module testbench;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, uframe_start = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0, lat = 4'h0;
    logic [2:0] uframe_index = 3'h0;
    logic [4:0] bus_frame_number = 5'h0;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, xact_req, xact_ack, xact_done, irq;
    iso_desc_pkg::xact_req_t xact_cmd, exp_cmd;
    iso_desc_pkg::xact_res_t xact_result, res = 16'h0;
    int errors = 0, checked = 0;

    always #5 aclk = ~aclk;

    iso_desc_engine dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .uframe_start(uframe_start),
        .uframe_index(uframe_index), .bus_frame_number(bus_frame_number), .xact_req(xact_req),
        .xact_cmd(xact_cmd), .xact_ack(xact_ack), .xact_done(xact_done), .xact_result(xact_result), .irq(irq));

    iso_bus_executor exec_u (.aclk(aclk), .aresetn(aresetn), .xact_req(xact_req), .lat(lat), .res_in(res),
        .xact_ack(xact_ack), .xact_done(xact_done), .xact_result(xact_result));

    task automatic give_verdict();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Write: both channels offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        if (n >= 50) begin errors++; give_verdict(); end
        `chk("bresp", er, bresp)
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        if (n >= 50) begin errors++; give_verdict(); end
        `chk("rresp", er, rresp)
        `chk("rdata", e, rdata)
    endtask

    // One micro-frame start; when a request is expected, check it and wait for its outcome
    task automatic uf(input logic [2:0] i, input logic [4:0] f, input logic [3:0] l,
            input iso_desc_pkg::xact_res_t r, input logic go, input logic eirq);
        int n;
        @(posedge aclk);
        uframe_start <= 1'b1;
        uframe_index <= i;
        bus_frame_number <= f;
        lat <= l;
        res <= r;
        @(posedge aclk);
        uframe_start <= 1'b0;
        #1;
        `chk("xact_req", go, xact_req)
        if (go) begin
            `chk("xact_cmd", exp_cmd, xact_cmd)
            n = 0;
            while (xact_done !== 1'b1 && n < 40) begin @(posedge aclk); #1; n++; end
            if (n >= 40) begin errors++; give_verdict(); end
            repeat (3) @(posedge aclk);
            #1;
            `chk("irq", eirq, irq)
        end
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, unmapped address and the read-only status word
        rd(`REG_CTRL, 32'h0, `RESP_OKAY);
        rd(`REG_IRQ_MASK, 32'h0, `RESP_OKAY);
        rd(`REG_ENGINE, 32'h1, `RESP_OKAY);
        rd(8'h40, 32'h0, `RESP_SLVERR);
        wr(8'h40, 32'hffff_ffff, `RESP_SLVERR);
        wr(`REG_IRQ_STAT, 32'h7, `RESP_OKAY);
        rd(`REG_IRQ_STAT, 32'h0, `RESP_OKAY);
        // IN, split, frame 0x0b with its don't-care bits set, micro-frames 0 and 2
        wr(8'h00, 32'hd000_4001, `RESP_OKAY);
        wr(8'h04, 32'h0000_5555, `RESP_OKAY);
        wr(8'h08, 32'h0012_345f, `RESP_OKAY);
        wr(8'h0c, 32'h8000_0000, `RESP_OKAY);
        wr(8'h10, 32'h0000_0005, `RESP_OKAY);
        wr(`REG_IRQ_MASK, 32'h7, `RESP_OKAY);
        wr(`REG_CTRL, 32'h1, `RESP_OKAY);
        exp_cmd = {2'h1, 1'b1, 7'h2a, 4'hb, 11'h400, 2'h2, 16'h1234};
        uf(3'h1, 5'h0b, 4'h0, 16'h0, 1'b0, 1'b0);
        uf(3'h0, 5'h0c, 4'h0, 16'h0, 1'b0, 1'b0);
        uf(3'h0, 5'h0b, 4'h0, {12'h100, 4'he}, 1'b1, 1'b1);
        rd(8'h10, 32'h0000_0304, `RESP_OKAY);
        rd(8'h14, 32'h0000_0100, `RESP_OKAY);
        rd(8'h0c, 32'h8000_0100, `RESP_OKAY);
        rd(`REG_IRQ_STAT, 32'h1, `RESP_OKAY);
        rd(`REG_IRQ_STAT, 32'h0, `RESP_OKAY);
        `chk("irq", 1'b0, irq)
        // Slow executor on the last enabled micro-frame
        uf(3'h2, 5'h0b, 4'h3, {12'hfff, 4'h0}, 1'b1, 1'b1);
        rd(8'h14, 32'hff00_0100, `RESP_OKAY);
        rd(8'h18, 32'h0000_000f, `RESP_OKAY);
        rd(8'h0c, 32'h0000_10ff, `RESP_OKAY);
        rd(8'h00, 32'hd000_4000, `RESP_OKAY);
        rd(8'h10, 32'h0000_0300, `RESP_OKAY);
        rd(`REG_IRQ_STAT, 32'h3, `RESP_OKAY);
        uf(3'h2, 5'h0b, 4'h0, 16'h0, 1'b0, 1'b0);
        // OUT with a stall, interrupts masked
        wr(`REG_IRQ_MASK, 32'h0, `RESP_OKAY);
        wr(8'h00, 32'hd000_4001, `RESP_OKAY);
        wr(8'h04, 32'h0000_5155, `RESP_OKAY);
        wr(8'h0c, 32'h8000_0000, `RESP_OKAY);
        wr(8'h10, 32'h0000_00ff, `RESP_OKAY);
        exp_cmd.token = 2'h0;
        uf(3'h3, 5'h0b, 4'h1, {12'h020, 4'h7}, 1'b1, 1'b0);
        rd(8'h10, 32'h0008_00f7, `RESP_OKAY);
        rd(8'h0c, 32'h4000_0020, `RESP_OKAY);
        rd(8'h00, 32'hd000_4000, `RESP_OKAY);
        rd(`REG_IRQ_STAT, 32'h7, `RESP_OKAY);
        uf(3'h4, 5'h0b, 4'h0, 16'h0, 1'b0, 1'b0);
        // Halt cleared by software, but a non-isochronous kind must still never run
        wr(8'h04, 32'h0000_4155, `RESP_OKAY);
        wr(8'h0c, 32'h8000_0000, `RESP_OKAY);
        wr(8'h00, 32'hd000_4001, `RESP_OKAY);
        uf(3'h4, 5'h0b, 4'h0, 16'h0, 1'b0, 1'b0);
        rd(8'h0c, 32'h8000_0000, `RESP_OKAY);
        rd(`REG_ENGINE, 32'h0000_0031, `RESP_OKAY);
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
